// ---- verif/sbwm_ctrl_model.sv ----
// Purpose: far-side controller model driving write bursts
// Assumes: pin clocks slow against pclk, ph pclk cycles per phase
// Notes:   pin clocks stand still between bursts
`timescale 1ns/10ps
module sbwm_ctrl_model (
  // clock
  input  wire logic clk,
  // write port pins
  output logic        k_pos,
  output logic        k_neg,
  output logic        rw_select,
  output logic        load_strobe_n,
  output logic [3:0]  wr_addr,
  output logic [35:0] wr_data,
  output logic [3:0]  byte_lane_select_n,
  output logic [1:0]  nibble_lane_select_n
);
  int ph = 6;

  initial begin
    k_pos = 1'b0;
    k_neg = 1'b0;
    rw_select = 1'b1;
    load_strobe_n = 1'b1;
    wr_addr = 4'h0;
    wr_data = 36'h0;
    {byte_lane_select_n, nibble_lane_select_n} = 6'h3F;
  end

  task automatic hold();
    repeat (ph) @(posedge clk);
  endtask : hold

  // ==========================================================================
  // one burst: start, word0 at k_pos, word1 at k_neg
  task automatic burst(input logic st, input logic [3:0] a, input logic [35:0] d0,
                       input logic [35:0] d1, input logic [5:0] s0, input logic [5:0] s1);
    @(posedge clk);
    rw_select <= ~st;
    load_strobe_n <= ~st;
    wr_addr <= a;
    hold();
    k_pos <= 1'b1;
    hold();
    k_pos <= 1'b0;
    rw_select <= 1'b1;
    load_strobe_n <= 1'b1;
    wr_data <= d0;
    {byte_lane_select_n, nibble_lane_select_n} <= s0;
    hold();
    k_pos <= 1'b1;
    hold();
    k_pos <= 1'b0;
    wr_data <= d1;
    {byte_lane_select_n, nibble_lane_select_n} <= s1;
    hold();
    k_neg <= 1'b1;
    hold();
    k_neg <= 1'b0;
    wr_data <= ~d1;
    wr_addr <= ~a;
    {byte_lane_select_n, nibble_lane_select_n} <= ~s1;
    hold();
  endtask : burst
endmodule : sbwm_ctrl_model

// ---- verif/sram_byte_write_masking_tb_top.sv ----
// Purpose: self-checking bench for lane write masking
// Assumes: zero-wait apb, partner model drives the pins
// Notes:   expected words built from own lane maps
`timescale 1ns/10ps
module sram_byte_write_masking_tb_top;
  // ==========================================================================
  // signals
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic        k_pos, k_neg, rw_select, load_strobe_n, capture_ready;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  wr_addr, byte_lane_select_n;
  logic [35:0] wr_data;
  logic [1:0]  nibble_lane_select_n;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cycles = 0;

  sbwm_top #(.ADDR_W(4)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .k_pos, .k_neg, .rw_select, .load_strobe_n,
    .wr_addr, .wr_data, .byte_lane_select_n, .nibble_lane_select_n, .capture_ready);
  sbwm_ctrl_model i_ctrl (.clk(pclk), .k_pos, .k_neg, .rw_select, .load_strobe_n,
    .wr_addr, .wr_data, .byte_lane_select_n, .nibble_lane_select_n);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  // ==========================================================================
  // helpers
  function automatic logic [35:0] lane_en(input logic [1:0] m, input logic [5:0] s);
    logic [35:0] e;
    e = '0;
    case (m)
      2'h0: e[7:0] = {{4{~s[1]}}, {4{~s[0]}}};
      2'h1: e[8:0] = {9{~s[2]}};
      2'h2: e[17:0] = {{9{~s[3]}}, {9{~s[2]}}};
      default: e = {{9{~s[5]}}, {9{~s[4]}}, {9{~s[3]}}, {9{~s[2]}}};
    endcase
    return e;
  endfunction : lane_en

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic rd_word(input logic [4:0] i, output logic [35:0] w);
    apb(1'b1, 8'h08, {27'h0, i});
    apb(1'b0, 8'h0C, 32'h0);
    w[31:0] = q;
    apb(1'b0, 8'h10, 32'h0);
    w[35:32] = q[3:0];
  endtask : rd_word

  task automatic settle();
    for (int i = 0; i < 200; i++) begin
      apb(1'b0, 8'h04, 32'h0);
      if (q[3:0] === 4'h1) break;
    end
  endtask : settle

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", 36'h4, 36'(q));
    apb(1'b0, 8'h04, 32'h0);
    chk("status", 36'h1, 36'(q));
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 36'h1, {q, 3'h0, serr});
  endtask : t_reset

  task automatic mode_case(input logic [1:0] m, input logic [3:0] a, input logic [5:0] s0,
                           input logic [5:0] s1);
    logic [35:0] d, e0, e1, wm, w;
    logic [31:0] c;
    d  = {a, 32'hA5C3_3C5A};
    e0 = lane_en(m, s0);
    e1 = lane_en(m, s1);
    wm = lane_en(m, 6'h00);
    apb(1'b1, 8'h00, {29'h0, 1'b1, m});
    apb(1'b0, 8'h14, 32'h0);
    c = q;
    i_ctrl.burst(1'b1, a, d, ~d, 6'h00, 6'h00);
    i_ctrl.burst(1'b1, a, ~d, d, s0, s1);
    i_ctrl.burst(1'b1, a, d, d, 6'h3F, 6'h3F);
    settle();
    rd_word({a, 1'b0}, w);
    chk("word0", (d ^ e0) & wm, w & wm);
    rd_word({a, 1'b1}, w);
    chk("word1", (~d ^ e1) & wm, w & wm);
    apb(1'b0, 8'h14, 32'h0);
    chk("wr_cnt", 36'(c + 32'd2 + 32'(e0 != '0) + 32'(e1 != '0)), 36'(q));
  endtask : mode_case

  task automatic t_no_start();
    logic [35:0] w0, w;
    logic [31:0] c;
    apb(1'b0, 8'h14, 32'h0);
    c = q;
    rd_word(5'h0A, w0);
    i_ctrl.burst(1'b0, 4'h5, 36'h0, 36'h0, 6'h00, 6'h00);
    settle();
    rd_word(5'h0A, w);
    chk("idle_word", w0, w);
    apb(1'b0, 8'h14, 32'h0);
    chk("idle_cnt", 36'(c), 36'(q));
  endtask : t_no_start

  task automatic t_fifo();
    logic [31:0] c;
    apb(1'b0, 8'h14, 32'h0);
    c = q;
    apb(1'b1, 8'h00, 32'hF);
    i_ctrl.ph = 9;
    for (int i = 0; i < 17; i++) begin
      i_ctrl.burst(1'b1, 4'(i), 36'h0, 36'h0, 6'h00, 6'h00);
    end
    apb(1'b0, 8'h04, 32'h0);
    chk("full", 36'h0_0021_0102, 36'(q));
    chk("cap_ready", 36'h0, 36'(capture_ready));
    apb(1'b1, 8'h00, 32'h7);
    settle();
    apb(1'b0, 8'h14, 32'h0);
    chk("drained", 36'(c + 32'd33), 36'(q));
  endtask : t_fifo

  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // ==========================================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    mode_case(2'h0, 4'h1, 6'b111110, 6'b111101);
    mode_case(2'h0, 4'h2, 6'b000011, 6'b111100);
    mode_case(2'h1, 4'h3, 6'b111000, 6'b111111);
    mode_case(2'h2, 4'h6, 6'b000111, 6'b111011);
    mode_case(2'h3, 4'h5, 6'b110111, 6'b011111);
    mode_case(2'h3, 4'h7, 6'b101111, 6'b111000);
    t_no_start();
    t_fifo();
    end_sim();
  end
endmodule : sram_byte_write_masking_tb_top

// ---- verilog/sbwm_fifo.sv ----
// Purpose: word FIFO with registered output between capture and array
// Assumes: DEPTH a power of two
// Notes:   out_data comes from a flop; level counts the output stage too
`timescale 1ns/10ps
module sbwm_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32,
  parameter int CW    = $clog2(DEPTH) + 1
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // filling side
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  // draining side
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  // fill level
  output logic [CW:0]        level
);

  localparam int PW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin
      $error("sbwm_fifo: bad W or DEPTH");
    end
  end

  logic [W-1:0]  mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [CW-1:0] cnt_ff;
  logic          ov_ff;
  logic [W-1:0]  od_ff;
  logic          push;
  logic          load;

  assign in_ready  = (cnt_ff != CW'(DEPTH));
  assign push      = in_valid & in_ready;
  assign load      = (cnt_ff != '0) & (~ov_ff | out_ready);
  assign out_valid = ov_ff;
  assign out_data  = od_ff;
  assign level     = {1'b0, cnt_ff} + {{CW{1'b0}}, ov_ff};

  // ==========================================================================
  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // ==========================================================================
  // pointers and count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + PW'(1);
      end
      if (load) begin
        rd_ptr_ff <= rd_ptr_ff + PW'(1);
      end
      cnt_ff <= cnt_ff + CW'(push) - CW'(load);
    end
  end

  // ==========================================================================
  // output stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_ff <= 1'b0;
      od_ff <= '0;
    end else begin
      if (load) begin
        ov_ff <= 1'b1;
        od_ff <= mem_ff[rd_ptr_ff];
      end else if (out_ready) begin
        ov_ff <= 1'b0;
      end
    end
  end

endmodule : sbwm_fifo

// ---- verilog/sbwm_pkg.sv ----
// Purpose: shared constants and lane decode for the write masking block
// Assumes: 36-bit widest organisation, nine-bit lanes, four-bit nibbles
// Notes:   all offsets are byte addresses on a 32-bit APB
package sbwm_pkg;

  // ==========================================================================
  // data organisation
  localparam int          DATA_W    = 36;
  localparam int          LANES     = 4;
  localparam int          LANE_W    = 9;
  localparam int          NIB_W     = 4;
  localparam logic [1:0]  ORG_X8    = 2'h0;
  localparam logic [1:0]  ORG_X9    = 2'h1;
  localparam logic [1:0]  ORG_X18   = 2'h2;
  localparam logic [1:0]  ORG_X36   = 2'h3;

  // ==========================================================================
  // register map
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_RD_IDX   = 8'h08;
  localparam logic [7:0]  ADDR_RD_LO    = 8'h0C;
  localparam logic [7:0]  ADDR_RD_HI    = 8'h10;
  localparam logic [7:0]  ADDR_WR_CNT   = 8'h14;

  // ==========================================================================
  // fields and reset values
  localparam int          CTRL_MODE_LSB  = 0;
  localparam int          CTRL_EN_BIT    = 2;
  localparam int          CTRL_HOLD_BIT  = 3;
  localparam logic [3:0]  CTRL_RESET     = 4'h4;
  localparam int          STAT_EMPTY_BIT = 0;
  localparam int          STAT_FULL_BIT  = 1;
  localparam int          STAT_PEND0_BIT = 2;
  localparam int          STAT_PEND1_BIT = 3;
  localparam int          STAT_DROP_LSB  = 8;
  localparam int          STAT_LVL_LSB   = 16;
  localparam int          DROP_W         = 8;
  localparam int          FIFO_DEPTH     = 32;

  // ==========================================================================
  // per-bit write enable from the active-low lane selects
  function automatic logic [DATA_W-1:0] sbwm_lane_en(
    input logic [1:0]       mode,
    input logic [LANES-1:0] bsel_n,
    input logic [1:0]       nsel_n
  );
    logic [DATA_W-1:0] en;
    en = '0;
    unique case (mode)
      ORG_X8: begin
        en[NIB_W-1:0]         = {NIB_W{~nsel_n[0]}};
        en[2*NIB_W-1:NIB_W]   = {NIB_W{~nsel_n[1]}};
      end
      ORG_X9: begin
        en[LANE_W-1:0]        = {LANE_W{~bsel_n[0]}};
      end
      ORG_X18: begin
        en[LANE_W-1:0]        = {LANE_W{~bsel_n[0]}};
        en[2*LANE_W-1:LANE_W] = {LANE_W{~bsel_n[1]}};
      end
      ORG_X36: begin
        for (int i = 0; i < LANES; i++) begin
          en[i*LANE_W +: LANE_W] = {LANE_W{~bsel_n[i]}};
        end
      end
    endcase
    return en;
  endfunction : sbwm_lane_en

endpackage : sbwm_pkg

// ---- verilog/sbwm_top.sv ----
// Purpose: byte-lane write masking on the write data port of a burst SRAM
// Assumes: k_pos, k_neg and all pins are slow against pclk (pin clock <= pclk/4)
// Notes:   array is read back over APB; a FIFO decouples capture from array writes
`timescale 1ns/10ps

module sbwm_top #(
  parameter int ADDR_W = 4
) (
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [7:0]                 paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  // sram write port pins
  input  wire logic                       k_pos,
  input  wire logic                       k_neg,
  input  wire logic                       rw_select,
  input  wire logic                       load_strobe_n,
  input  wire logic [ADDR_W-1:0]          wr_addr,
  input  wire logic [sbwm_pkg::DATA_W-1:0] wr_data,
  input  wire logic [sbwm_pkg::LANES-1:0] byte_lane_select_n,
  input  wire logic [1:0]                 nibble_lane_select_n,
  // capture status
  output logic                            capture_ready
);

  localparam int IDX_W = ADDR_W + 1;
  localparam int WORDS = 1 << IDX_W;
  localparam int DW    = sbwm_pkg::DATA_W;
  localparam int EW    = IDX_W + 2 * DW;
  localparam int SW    = 4 + ADDR_W + DW + sbwm_pkg::LANES + 2;
  localparam int LW    = $clog2(sbwm_pkg::FIFO_DEPTH) + 2;

  initial begin
    if (ADDR_W < 1 || ADDR_W > 10) begin
      $error("sbwm_top: ADDR_W out of range");
    end
  end

  // ==========================================================================
  // pin synchronisers
  logic [SW-1:0] sync1_ff;
  logic [SW-1:0] sync2_ff;
  logic          kp_prev_ff;
  logic          kn_prev_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff   <= '0;
      sync2_ff   <= '0;
      kp_prev_ff <= 1'b0;
      kn_prev_ff <= 1'b0;
    end else begin
      sync1_ff   <= {k_pos, k_neg, rw_select, load_strobe_n, wr_addr, wr_data,
                     byte_lane_select_n, nibble_lane_select_n};
      sync2_ff   <= sync1_ff;
      kp_prev_ff <= sync2_ff[SW-1];
      kn_prev_ff <= sync2_ff[SW-2];
    end
  end

  logic                       s_kp;
  logic                       s_kn;
  logic                       s_rw;
  logic                       s_ld_n;
  logic [ADDR_W-1:0]          s_addr;
  logic [DW-1:0]              s_data;
  logic [sbwm_pkg::LANES-1:0] s_bsel_n;
  logic [1:0]                 s_nsel_n;

  assign {s_kp, s_kn, s_rw, s_ld_n, s_addr, s_data, s_bsel_n, s_nsel_n} = sync2_ff;

  // ==========================================================================
  // control register
  logic [3:0]  ctrl_ff;
  logic [1:0]  mode;
  logic        cap_en;
  logic        drain_hold;

  assign mode       = ctrl_ff[sbwm_pkg::CTRL_MODE_LSB +: 2];
  assign cap_en     = ctrl_ff[sbwm_pkg::CTRL_EN_BIT];
  assign drain_hold = ctrl_ff[sbwm_pkg::CTRL_HOLD_BIT];

  // ==========================================================================
  // write initiation and burst capture
  logic              kp_rise;
  logic              kn_rise;
  logic              start_wr;
  logic              pend0_ff;
  logic              pend1_ff;
  logic [ADDR_W-1:0] addr0_ff;
  logic [ADDR_W-1:0] addr1_ff;
  logic              cap0;
  logic              cap1;
  logic [IDX_W-1:0]  cap_idx;
  logic [DW-1:0]     cap_lane;
  logic              push_req;
  logic              fifo_push;
  logic              fifo_in_ready;

  assign kp_rise  = s_kp & ~kp_prev_ff;
  assign kn_rise  = s_kn & ~kn_prev_ff;
  assign start_wr = kp_rise & ~s_rw & ~s_ld_n & cap_en;
  assign cap0     = kp_rise & pend0_ff;
  assign cap1     = kn_rise & pend1_ff;
  assign cap_idx  = cap0 ? {addr0_ff, 1'b0} : {addr1_ff, 1'b1};
  assign cap_lane = sbwm_pkg::sbwm_lane_en(mode, s_bsel_n, s_nsel_n);
  assign push_req = (cap0 | cap1) & (|cap_lane);
  assign fifo_push     = push_req & fifo_in_ready;
  assign capture_ready = fifo_in_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend0_ff <= 1'b0;
      addr0_ff <= '0;
    end else if (kp_rise) begin
      pend0_ff <= start_wr;
      if (start_wr) begin
        addr0_ff <= s_addr;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend1_ff <= 1'b0;
      addr1_ff <= '0;
    end else if (cap0) begin
      pend1_ff <= 1'b1;
      addr1_ff <= addr0_ff;
    end else if (kn_rise) begin
      pend1_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // capture fifo
  logic [EW-1:0] fifo_out;
  logic          fifo_out_valid;
  logic          drain;
  logic [LW-1:0] fifo_level;

  assign drain = fifo_out_valid & ~drain_hold;

  sbwm_fifo #(
    .W     (EW),
    .DEPTH (sbwm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   ({cap_idx, cap_lane, s_data}),
    .out_valid (fifo_out_valid),
    .out_ready (~drain_hold),
    .out_data  (fifo_out),
    .level     (fifo_level)
  );

  // ==========================================================================
  // array with masked write
  logic [DW-1:0]    arr_ff [WORDS];
  logic [IDX_W-1:0] d_idx;
  logic [DW-1:0]    d_en;
  logic [DW-1:0]    d_data;

  assign {d_idx, d_en, d_data} = fifo_out;

  always_ff @(posedge pclk) begin
    if (drain) begin
      arr_ff[d_idx] <= (arr_ff[d_idx] & ~d_en) | (d_data & d_en);
    end
  end

  // ==========================================================================
  // counters
  logic [sbwm_pkg::DROP_W-1:0] drop_cnt_ff;
  logic [31:0]                 wr_cnt_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drop_cnt_ff <= '0;
    end else if (push_req & ~fifo_in_ready & ~(&drop_cnt_ff)) begin
      drop_cnt_ff <= drop_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_cnt_ff <= '0;
    end else if (drain) begin
      wr_cnt_ff <= wr_cnt_ff + 32'h0000_0001;
    end
  end

  // ==========================================================================
  // apb slave
  logic [IDX_W-1:0] rd_idx_ff;
  logic [31:0]      prdata_ff;
  logic             wr_acc;
  logic             rd_setup;
  logic             hit;
  logic [31:0]      status;
  logic [DW-1:0]    rd_word;

  assign hit = (paddr == sbwm_pkg::ADDR_CTRL)   || (paddr == sbwm_pkg::ADDR_STATUS) ||
               (paddr == sbwm_pkg::ADDR_RD_IDX) || (paddr == sbwm_pkg::ADDR_RD_LO)  ||
               (paddr == sbwm_pkg::ADDR_RD_HI)  || (paddr == sbwm_pkg::ADDR_WR_CNT);
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~hit;
  assign prdata   = prdata_ff;
  assign rd_word  = arr_ff[rd_idx_ff];

  always_comb begin
    status = 32'h0000_0000;
    status[sbwm_pkg::STAT_EMPTY_BIT] = ~fifo_out_valid;
    status[sbwm_pkg::STAT_FULL_BIT]  = ~fifo_in_ready;
    status[sbwm_pkg::STAT_PEND0_BIT] = pend0_ff;
    status[sbwm_pkg::STAT_PEND1_BIT] = pend1_ff;
    status[sbwm_pkg::STAT_DROP_LSB +: sbwm_pkg::DROP_W] = drop_cnt_ff;
    status[sbwm_pkg::STAT_LVL_LSB +: LW] = fifo_level;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff   <= sbwm_pkg::CTRL_RESET;
      rd_idx_ff <= '0;
    end else if (wr_acc) begin
      if (paddr == sbwm_pkg::ADDR_CTRL) begin
        ctrl_ff <= pwdata[3:0];
      end
      if (paddr == sbwm_pkg::ADDR_RD_IDX) begin
        rd_idx_ff <= pwdata[IDX_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_setup) begin
      unique case (paddr)
        sbwm_pkg::ADDR_CTRL:   prdata_ff <= {28'h000_0000, ctrl_ff};
        sbwm_pkg::ADDR_STATUS: prdata_ff <= status;
        sbwm_pkg::ADDR_RD_IDX: prdata_ff <= {{(32-IDX_W){1'b0}}, rd_idx_ff};
        sbwm_pkg::ADDR_RD_LO:  prdata_ff <= rd_word[31:0];
        sbwm_pkg::ADDR_RD_HI:  prdata_ff <= {28'h000_0000, rd_word[DW-1:32]};
        sbwm_pkg::ADDR_WR_CNT: prdata_ff <= wr_cnt_ff;
        default:               prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic             chk_v_ff;
  logic [IDX_W-1:0] chk_idx_ff;
  logic [DW-1:0]    chk_exp_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_v_ff   <= 1'b0;
      chk_idx_ff <= '0;
      chk_exp_ff <= '0;
    end else begin
      chk_v_ff   <= drain;
      chk_idx_ff <= d_idx;
      chk_exp_ff <= (arr_ff[d_idx] & ~d_en) | (d_data & d_en);
    end
  end

  AST_PUSH_IN_DATA_PHASE: assert property (
    push_req |-> $past(start_wr, 1) == 1'b0 && (pend0_ff || pend1_ff) && (kp_rise || kn_rise))
    else $error("push outside data portion of a write");

  AST_SECOND_HALF_ARMED: assert property (
    cap0 |=> pend1_ff && addr1_ff == $past(addr0_ff) && !cap0)
    else $error("second burst half not armed after first");

  AST_X8_BOTH: assert property (
    push_req && mode == sbwm_pkg::ORG_X8 && s_nsel_n == 2'h0 |-> cap_lane == 36'h0_0000_00FF)
    else $error("x8 full word enable wrong");

  AST_X8_LOWER: assert property (
    push_req && mode == sbwm_pkg::ORG_X8 && s_nsel_n == 2'h2 |-> cap_lane == 36'h0_0000_000F)
    else $error("x8 lower nibble enable wrong");

  AST_X8_UPPER: assert property (
    push_req && mode == sbwm_pkg::ORG_X8 && s_nsel_n == 2'h1 |-> cap_lane == 36'h0_0000_00F0)
    else $error("x8 upper nibble enable wrong");

  AST_X18_BOTH: assert property (
    push_req && mode == sbwm_pkg::ORG_X18 && s_bsel_n[1:0] == 2'h0
    |-> cap_lane == 36'h0_0003_FFFF)
    else $error("x18 full word enable wrong");

  AST_X18_LOWER: assert property (
    push_req && mode == sbwm_pkg::ORG_X18 && s_bsel_n[1:0] == 2'h2
    |-> cap_lane == 36'h0_0000_01FF)
    else $error("x18 lower lane enable wrong");

  AST_X18_UPPER: assert property (
    push_req && mode == sbwm_pkg::ORG_X18 && s_bsel_n[1:0] == 2'h1
    |-> cap_lane == 36'h0_0003_FE00)
    else $error("x18 upper lane enable wrong");

  AST_X36_ALL: assert property (
    push_req && mode == sbwm_pkg::ORG_X36 && s_bsel_n == 4'h0 |-> cap_lane == 36'hF_FFFF_FFFF)
    else $error("x36 full word enable wrong");

  AST_X36_LANE2: assert property (
    push_req && mode == sbwm_pkg::ORG_X36 && s_bsel_n == 4'hB |-> cap_lane == 36'h0_07FC_0000)
    else $error("x36 lane 2 enable wrong");

  AST_X9_WORD: assert property (
    (cap0 || cap1) && mode == sbwm_pkg::ORG_X9
    |-> push_req == !s_bsel_n[0] && (!push_req || cap_lane == 36'h0_0000_01FF))
    else $error("x9 word select wrong");

  AST_ALL_HIGH_NO_WRITE: assert property (
    (cap0 || cap1) && mode == sbwm_pkg::ORG_X36 && s_bsel_n == 4'hF |-> !push_req)
    else $error("write queued with every select high");

  AST_MERGE_KEEPS_LANES: assert property (
    chk_v_ff |-> ((arr_ff[chk_idx_ff] ^ chk_exp_ff)
                  & sbwm_pkg::sbwm_lane_en(mode, '0, '0)) == '0)
    else $error("array merge touched a deselected lane");

  COV_FIRST_HALF:  cover property (cap0 && push_req);
  COV_SECOND_HALF: cover property (cap1 && push_req);
  COV_FIFO_FULL:   cover property (!fifo_in_ready);
  COV_BACK2BACK:   cover property (start_wr && pend0_ff);

endmodule : sbwm_top
